// File: src/ldrc_pkg.sv
// package: register map, field layout and timing constants of the config bank
package ldrc_pkg;

   // register addresses (8-bit map, 16-bit data)
   localparam logic [7:0] ADDR_GLOBAL_CTRL   = 8'h01;
   localparam logic [7:0] ADDR_CH8_COEF_BASE = 8'hAE;
   localparam logic [7:0] ADDR_CH8_COEF_LAST = 8'hB9;
   localparam logic [7:0] ADDR_EDGE_DELAY    = 8'hBE;
   localparam logic [7:0] ADDR_REF_SELECT    = 8'hF0;
   localparam logic [7:0] ADDR_STATUS        = 8'hF8;

   // field positions
   localparam int UPPER_MAP_BIT     = 4;
   localparam int EN_BIT            = 15;
   localparam int DATA_RISE_LSB     = 8;
   localparam int BITCLK_RISE_LSB   = 5;
   localparam int DATA_FALL_LSB     = 3;
   localparam int BITCLK_FALL_LSB   = 0;

   // reset values
   localparam logic [15:0] RST_REG16 = 16'h0000;
   localparam logic [11:0] RST_COEF  = 12'h000;

   // coefficient count per channel and pipeline latency
   localparam int NUM_COEF      = 12;
   localparam int PIPE_LATENCY  = 12;
   localparam int SAMPLE_WIDTH  = 12;
   localparam int NUM_CH        = 8;

   // clock-detect qualification time
   localparam int CLK_PERIOD_NS    = 100;
   localparam int SE_DETECT_NS     = 800;
   localparam int SE_DETECT_CYCLES = (SE_DETECT_NS + CLK_PERIOD_NS - 1)
                                     / CLK_PERIOD_NS;

   // register bus carrier
   typedef struct packed {
      logic [7:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } ldrc_bus_type;

   // decoded edge-delay settings
   typedef struct packed {
      logic [1:0] data_rise;
      logic [2:0] bitclk_rise;
      logic [1:0] data_fall;
      logic [2:0] bitclk_fall;
   } ldrc_delay_type;

   // clock-detect machine states, gray along the path
   typedef enum logic [1:0] {
      ST_DIFF    = 2'b00,
      ST_QUALIFY = 2'b01,
      ST_SINGLE  = 2'b11
   } ldrc_clk_state_type;

endpackage

// File: src/ldrc_pipe.sv
// one converter channel's twelve-stage output pipeline
`timescale 1ns/1ps
module ldrc_pipe #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 12
) (
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rst_n,
   // sample in, data out
   input  wire logic [WIDTH-1:0] sample,
   output logic      [WIDTH-1:0] data_out
);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] stage;
   } ldrc_pipe_state_type;

   ldrc_pipe_state_type st;
   ldrc_pipe_state_type next_st;

   // shift one stage per clock edge
   always_comb begin
      next_st = st;
      next_st.stage[0] = sample;
      for (int i = 1; i < DEPTH; i++) begin
         next_st.stage[i] = st.stage[i-1];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign data_out = st.stage[DEPTH-1];
endmodule

// File: src/ldrc_top.sv
// edge-delay, reference-select and channel-8 coefficient config bank
// Overview of operation
// [RULE_01] Low 12 bits of each ch8 coefficient register are coefficient n.
// [RULE_02] Custom enable 0 selects built-in, 1 selects custom coefficients.
// [RULE_03] Edge-delay bit 15 gates whether the delay fields take effect.
// [RULE_04] Data delay fields: rise at bits 9:8, fall at bits 4:3.
// [RULE_05] Bit-clock delay fields: rise at bits 7:5, fall at bits 2:0.
// [RULE_06] Host sets upper-map access enable before touching ref select.
// [RULE_07] Reference select resets to internal; 1 selects external.
// [RULE_08] Host writes zero to the low fifteen bits of ref select.
// [RULE_09] External reference powers down internal reference amplifiers.
// [RULE_10] All eight channels sample together on the rising clock edge.
// [RULE_11] Each sample emerges twelve clock cycles after being taken.
// [RULE_12] A single-ended clock is detected alone and biasing switched off.
`timescale 1ns/1ps
module ldrc_top (
   // clock and reset
   input  wire logic                sys_clk,
   input  wire logic                rst_n,
   // register port
   input  wire ldrc_pkg::ldrc_bus_type bus,
   output logic [15:0]              rdata,
   // converter samples, all channels packed
   input  wire logic [95:0]         adc_sample,
   output logic [95:0]              adc_data,
   // clock input pins; only the negative pin is sampled, as a level
   input  wire logic                clock_input_pos,
   input  wire logic                clock_input_neg,
   // analog control outputs
   output logic                     clk_bias_enable,
   output logic                     ref_amp_powerdown,
   output logic                     ext_ref_mode,
   // filter and edge-delay controls
   output logic                     ch8_custom_filter_enable,
   output logic [143:0]             ch8_coef_bus,
   output ldrc_pkg::ldrc_delay_type edge_delay
);
   typedef struct packed {
      logic [15:0]                 rdata;
      logic                        upper_map_access_enable;
      logic                        ch8_custom_filter_enable;
      logic [11:0][11:0]           coef;
      logic [15:0]                 delay_reg;
      logic                        external_reference_select;
      ldrc_pkg::ldrc_delay_type    delay_out;
      logic [2:0]                  det_cnt;
      ldrc_pkg::ldrc_clk_state_type cstate;
      logic                        bias_en;
      logic                        amp_pd;
      logic                        ext_ref;
      logic                        filt_en;
   } ldrc_state_type;

   ldrc_state_type st;
   ldrc_state_type next_st;
   logic [3:0]     coef_idx;
   logic           in_coef;
   logic           neg_low;

   // coefficient index relative to the channel-8 base
   assign coef_idx = 4'(bus.addr - ldrc_pkg::ADDR_CH8_COEF_BASE);
   assign in_coef  = (bus.addr >= ldrc_pkg::ADDR_CH8_COEF_BASE) &&
                     (bus.addr <= ldrc_pkg::ADDR_CH8_COEF_LAST);
   // a grounded negative pin alone marks single-end; the positive pin is not looked at
   assign neg_low  = !clock_input_neg;

   // next-state: register writes, reads and clock detection
   always_comb begin
      next_st = st;
      next_st.rdata = 16'h0000;
      // writes
      if (bus.wr) begin
         if (bus.addr == ldrc_pkg::ADDR_GLOBAL_CTRL) begin
            next_st.upper_map_access_enable =
               bus.wdata[ldrc_pkg::UPPER_MAP_BIT];
         end else if (in_coef) begin
            // one enable shared by all twelve ch8 registers
            next_st.ch8_custom_filter_enable =
               bus.wdata[ldrc_pkg::EN_BIT];                  // [RULE_02]
            next_st.coef[coef_idx] = bus.wdata[11:0];        // [RULE_01]
         end else if (bus.addr == ldrc_pkg::ADDR_EDGE_DELAY) begin
            next_st.delay_reg = bus.wdata & 16'h83FF;
         end else if (bus.addr == ldrc_pkg::ADDR_REF_SELECT &&
                      st.upper_map_access_enable) begin      // [RULE_06]
            // low bits must be zero from the host, so only bit 15 is kept
            next_st.external_reference_select =
               bus.wdata[ldrc_pkg::EN_BIT];                  // [RULE_07]
         end
      end
      // reads, answered in the following cycle
      if (bus.rd) begin
         if (bus.addr == ldrc_pkg::ADDR_GLOBAL_CTRL) begin
            next_st.rdata[ldrc_pkg::UPPER_MAP_BIT] =
               st.upper_map_access_enable;
         end else if (in_coef) begin
            next_st.rdata = {st.ch8_custom_filter_enable, 3'h0,
                             st.coef[coef_idx]};
         end else if (bus.addr == ldrc_pkg::ADDR_EDGE_DELAY) begin
            next_st.rdata = st.delay_reg;
         end else if (bus.addr == ldrc_pkg::ADDR_REF_SELECT &&
                      st.upper_map_access_enable) begin      // [RULE_06]
            next_st.rdata = {st.external_reference_select, 15'h0000};
         end else if (bus.addr == ldrc_pkg::ADDR_STATUS) begin
            next_st.rdata = {14'h0000, st.cstate == ldrc_pkg::ST_SINGLE,
                             st.amp_pd};
         end
      end
      // delay fields take effect only while programmability is enabled
      if (st.delay_reg[ldrc_pkg::EN_BIT]) begin              // [RULE_03]
         next_st.delay_out.data_rise   =
            st.delay_reg[ldrc_pkg::DATA_RISE_LSB +: 2];      // [RULE_04]
         next_st.delay_out.data_fall   =
            st.delay_reg[ldrc_pkg::DATA_FALL_LSB +: 2];      // [RULE_04]
         next_st.delay_out.bitclk_rise =
            st.delay_reg[ldrc_pkg::BITCLK_RISE_LSB +: 3];    // [RULE_05]
         next_st.delay_out.bitclk_fall =
            st.delay_reg[ldrc_pkg::BITCLK_FALL_LSB +: 3];    // [RULE_05]
      end else begin
         next_st.delay_out = '0;
      end
      next_st.ext_ref = st.external_reference_select;
      next_st.amp_pd  = st.external_reference_select;        // [RULE_09]
      next_st.filt_en = st.ch8_custom_filter_enable;         // [RULE_02]
      // single-ended clock detector, no configuration involved
      case (st.cstate)
         ldrc_pkg::ST_DIFF: begin
            next_st.det_cnt = 3'h0;
            if (neg_low) begin
               next_st.cstate = ldrc_pkg::ST_QUALIFY;
            end
         end
         ldrc_pkg::ST_QUALIFY: begin
            if (!neg_low) begin
               next_st.cstate = ldrc_pkg::ST_DIFF;
            end else if (next_st.det_cnt ==
                         3'(ldrc_pkg::SE_DETECT_CYCLES - 1)) begin
               next_st.cstate = ldrc_pkg::ST_SINGLE;         // [RULE_12]
            end else begin
               next_st.det_cnt = st.det_cnt + 3'h1;
            end
         end
         ldrc_pkg::ST_SINGLE: begin
            if (!neg_low) begin
               next_st.cstate = ldrc_pkg::ST_DIFF;
            end
         end
         default: begin
            next_st.cstate = ldrc_pkg::ST_DIFF;
         end
      endcase
      next_st.bias_en = (next_st.cstate != ldrc_pkg::ST_SINGLE); // [RULE_12]
   end

   // state register
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st         <= '0;
         st.bias_en <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // every channel pipeline shares the one rising edge
   for (genvar ch = 0; ch < ldrc_pkg::NUM_CH; ch++) begin : g_ch
      ldrc_pipe #(
         .WIDTH (ldrc_pkg::SAMPLE_WIDTH),
         .DEPTH (ldrc_pkg::PIPE_LATENCY)
      ) u_pipe (
         .sys_clk  (sys_clk),
         .rst_n    (rst_n),
         .sample   (adc_sample[ch*12 +: 12]),                // [RULE_10]
         .data_out (adc_data[ch*12 +: 12])                   // [RULE_11]
      );
   end

   // outputs straight from state flops
   assign rdata                    = st.rdata;
   assign clk_bias_enable          = st.bias_en;
   assign ref_amp_powerdown        = st.amp_pd;
   assign ext_ref_mode             = st.ext_ref;
   assign ch8_custom_filter_enable = st.filt_en;
   assign ch8_coef_bus             = st.coef;
   assign edge_delay               = st.delay_out;

   // assertions
   property p_delay_gate;
      @(posedge sys_clk) disable iff (!rst_n)
      !st.delay_reg[15] |=> edge_delay == '0;
   endproperty
   a_delay_gate: assert property (p_delay_gate) // [RULE_03]
      else $error("delay fields active while disabled");

   property p_delay_fields;
      @(posedge sys_clk) disable iff (!rst_n)
      st.delay_reg[15] |=> edge_delay.data_rise == $past(st.delay_reg[9:8])
         && edge_delay.data_fall == $past(st.delay_reg[4:3]);
   endproperty
   a_delay_fields: assert property (p_delay_fields) // [RULE_04]
      else $error("data delay fields wrong");

   property p_clk_fields;
      @(posedge sys_clk) disable iff (!rst_n)
      st.delay_reg[15] |=> edge_delay.bitclk_rise == $past(st.delay_reg[7:5])
         && edge_delay.bitclk_fall == $past(st.delay_reg[2:0]);
   endproperty
   a_clk_fields: assert property (p_clk_fields) // [RULE_05]
      else $error("bit clock delay fields wrong");

   property p_ref_blocked;
      @(posedge sys_clk) disable iff (!rst_n)
      bus.wr && bus.addr == 8'hF0 && !st.upper_map_access_enable
         |=> $stable(st.external_reference_select);
   endproperty
   a_ref_blocked: assert property (p_ref_blocked) // [RULE_06]
      else $error("reference select written while locked");

   property p_ref_write;
      @(posedge sys_clk) disable iff (!rst_n)
      bus.wr && bus.addr == 8'hF0 && st.upper_map_access_enable
         |=> ##1 ext_ref_mode == $past(bus.wdata[15], 2);
   endproperty
   a_ref_write: assert property (p_ref_write) // [RULE_07]
      else $error("reference select not applied");

   property p_amp_pd;
      @(posedge sys_clk) disable iff (!rst_n)
      ref_amp_powerdown == ext_ref_mode;
   endproperty
   a_amp_pd: assert property (p_amp_pd) // [RULE_09]
      else $error("amplifier power-down mismatch");

   property p_coef;
      @(posedge sys_clk) disable iff (!rst_n)
      bus.wr && bus.addr == 8'hAE |=> ch8_coef_bus[11:0] ==
         $past(bus.wdata[11:0]);
   endproperty
   a_coef: assert property (p_coef) // [RULE_01]
      else $error("coefficient zero not stored");

   property p_filt;
      @(posedge sys_clk) disable iff (!rst_n)
      bus.wr && bus.addr == 8'hB0 |=> ##1
         ch8_custom_filter_enable == $past(bus.wdata[15], 2);
   endproperty
   a_filt: assert property (p_filt) // [RULE_02]
      else $error("custom filter enable not applied");

   property p_latency;
      @(posedge sys_clk) disable iff (!rst_n)
      ##12 adc_data[11:0] == $past(adc_sample[11:0], 12);
   endproperty
   a_latency: assert property (p_latency) // [RULE_11]
      else $error("pipeline latency not twelve");

   sequence s_neg_low8;
      !clock_input_neg [*8];
   endsequence
   property p_se_detect;
      @(posedge sys_clk) disable iff (!rst_n)
      s_neg_low8 ##1 !clock_input_neg |=> !clk_bias_enable;
   endproperty
   a_se_detect: assert property (p_se_detect) // [RULE_12]
      else $error("single-ended clock not detected");
endmodule

// File: testbench/ldrc_host_model.sv
// host model: drives the register port of the config bank
`timescale 1ns/1ps
module ldrc_host_model (
   // clock
   input  wire logic              sys_clk,
   // register port
   output ldrc_pkg::ldrc_bus_type bus,
   input  wire logic [15:0]       rdata
);
   initial begin
      bus = '0;
   end

   // one-cycle write; released lines show inverted values, never stale ones
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge sys_clk);
      bus <= '{addr: a, wdata: v, wr: 1'h1, rd: 1'h0};
      @(posedge sys_clk);
      bus <= '{addr: ~a, wdata: ~v, wr: 1'h0, rd: 1'h0};
   endtask

   // one-cycle read; data stand only in the following cycle
   task automatic rd(input logic [7:0] a, output logic [15:0] v);
      @(posedge sys_clk);
      bus <= '{addr: a, wdata: 16'h5A5A, wr: 1'h0, rd: 1'h1};
      @(posedge sys_clk);
      bus <= '{addr: ~a, wdata: 16'hA5A5, wr: 1'h0, rd: 1'h0};
      @(negedge sys_clk);
      v = rdata;
   endtask

   // upper map opened first, low bits of the select word kept at zero
   task automatic set_ref(input logic sel);
      wr(ldrc_pkg::ADDR_GLOBAL_CTRL, 16'h0010);
      wr(ldrc_pkg::ADDR_REF_SELECT, {sel, 15'h0000});
   endtask
endmodule

// File: testbench/test_ldrc_top.sv
// self-checking bench for the config bank
`timescale 1ns/1ps
module test_ldrc_top;
   logic                     sys_clk;
   logic                     rst_n;
   ldrc_pkg::ldrc_bus_type   bus;
   logic [15:0]              rdata;
   logic [95:0]              adc_sample;
   logic [95:0]              adc_data;
   logic                     clock_input_pos;
   logic                     clock_input_neg;
   logic                     clk_bias_enable;
   logic                     ref_amp_powerdown;
   logic                     ext_ref_mode;
   logic                     ch8_custom_filter_enable;
   logic [143:0]             ch8_coef_bus;
   ldrc_pkg::ldrc_delay_type edge_delay;
   int                       mismatches;
   int                       num_checks;
   int                       cycles;
   logic [15:0]              d;

   ldrc_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
      .adc_sample(adc_sample), .adc_data(adc_data),
      .clock_input_pos(clock_input_pos), .clock_input_neg(clock_input_neg),
      .clk_bias_enable(clk_bias_enable),
      .ref_amp_powerdown(ref_amp_powerdown), .ext_ref_mode(ext_ref_mode),
      .ch8_custom_filter_enable(ch8_custom_filter_enable),
      .ch8_coef_bus(ch8_coef_bus), .edge_delay(edge_delay));

   ldrc_host_model host (.sys_clk(sys_clk), .bus(bus), .rdata(rdata));

   // 100 ns clock
   initial begin
      sys_clk = 1'h0;
      forever #50 sys_clk = ~sys_clk;
   end

   task automatic finish_test;
      if (mismatches == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // register-sized and flag results
   task automatic chk16(input string n, input logic [15:0] e,
                        input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask

   // wide bus results: all eight packed channel samples
   task automatic chk_wide(input string n, input logic [95:0] e,
                           input logic [95:0] g);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask

   // distinct value per channel and per step
   function automatic logic [95:0] smp(input int i);
      logic [95:0] r;
      for (int c = 0; c < 8; c++) begin
         r[c*12 +: 12] = 12'(12'h100 + i * 8 + c);
      end
      return r;
   endfunction

   // watchdog: the whole run needs well under a thousand cycles
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         finish_test();
      end
   end

   // settle derived outputs, then look between edges
   task automatic settle;
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask

   initial begin
      rst_n = 1'h0;
      adc_sample = '0;
      clock_input_pos = 1'h1;
      clock_input_neg = 1'h1;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'h1;
      // reset state
      chk16("bias", 16'h0001, 16'(clk_bias_enable));
      chk16("extref", 16'h0000, 16'(ext_ref_mode));
      host.rd(ldrc_pkg::ADDR_REF_SELECT, d);
      chk16("ref_rd0", 16'h0000, d);
      // delay fields without the enable have no effect
      host.wr(ldrc_pkg::ADDR_EDGE_DELAY, 16'h7CB5);
      settle();
      chk16("delay_off", 16'h0000, 16'(edge_delay));
      host.rd(ldrc_pkg::ADDR_EDGE_DELAY, d);
      chk16("delay_rd", 16'h00B5, d);
      host.wr(ldrc_pkg::ADDR_EDGE_DELAY, 16'h82B5);
      settle();
      chk16("dly1", 16'h02B5, 16'(edge_delay));
      // select word blocked while the upper map is closed
      host.wr(ldrc_pkg::ADDR_REF_SELECT, 16'h8000);
      settle();
      chk16("ext_blk", 16'h0000, 16'(ext_ref_mode));
      host.set_ref(1'h1);
      settle();
      chk16("extref1", 16'h0001, 16'(ext_ref_mode));
      chk16("amp_pd", 16'h0001, 16'(ref_amp_powerdown));
      host.rd(ldrc_pkg::ADDR_REF_SELECT, d);
      chk16("ref_rd1", 16'h8000, d);
      host.rd(ldrc_pkg::ADDR_STATUS, d);
      chk16("status", 16'h0001, d);
      host.rd(8'h10, d);
      chk16("unmapped", 16'h0000, d);
      host.rd(ldrc_pkg::ADDR_GLOBAL_CTRL, d);
      chk16("upper_rd", 16'h0010, d);
      // closing the upper map hides the select word again
      host.wr(ldrc_pkg::ADDR_GLOBAL_CTRL, 16'h0000);
      host.rd(ldrc_pkg::ADDR_REF_SELECT, d);
      chk16("ref_hid", 16'h0000, d);
      host.wr(ldrc_pkg::ADDR_REF_SELECT, 16'h0000);
      settle();
      chk16("ext_hold", 16'h0001, 16'(ext_ref_mode));
      host.set_ref(1'h0);
      settle();
      chk16("amp_on", 16'h0000, 16'(ref_amp_powerdown));
      // all twelve coefficients, custom enable with the last one
      for (int n = 0; n < 12; n++) begin
         host.wr(8'(ldrc_pkg::ADDR_CH8_COEF_BASE + n),
                 {(n == 11) ? 4'h8 : 4'h0, 12'(12'h5A0 + n * 3)});
      end
      settle();
      for (int n = 0; n < 12; n++) begin
         d = 16'(ch8_coef_bus[n*12 +: 12]);
         chk16("coef", 16'(12'h5A0 + n * 3), d);
      end
      chk16("cust_en", 16'h0001, 16'(ch8_custom_filter_enable));
      host.rd(ldrc_pkg::ADDR_CH8_COEF_BASE, d);
      chk16("coef_rd", 16'h85A0, d);
      host.wr(ldrc_pkg::ADDR_CH8_COEF_LAST, 16'h0FFF);
      settle();
      chk16("cust_off", 16'h0000, 16'(ch8_custom_filter_enable));
      // every channel, every cycle, twelve cycles through the pipeline
      for (int i = 0; i < 32; i++) begin
         @(posedge sys_clk);
         adc_sample <= smp(i);
         @(negedge sys_clk);
         if (i >= 12) begin
            chk_wide("pipe", smp(i - 12), adc_data);
         end
      end
      // grounded negative clock pin: biasing drops, then returns
      @(posedge sys_clk);
      clock_input_neg <= 1'h0;
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      chk16("bias_wait", 16'h0001, 16'(clk_bias_enable));
      repeat (10) @(posedge sys_clk);
      @(negedge sys_clk);
      chk16("bias_off", 16'h0000, 16'(clk_bias_enable));
      host.rd(ldrc_pkg::ADDR_STATUS, d);
      chk16("se_stat", 16'h0002, d);
      @(posedge sys_clk);
      clock_input_neg <= 1'h1;
      settle();
      chk16("bias_on", 16'h0001, 16'(clk_bias_enable));
      finish_test();
   end
endmodule
